// file: src/heis_pkg.sv
// heis_pkg: constants shared by the error event flag block
// assumes a 16-bit register port with word indices as given below
package heis_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [7:0] ADDR_FLAGS       = 8'h32;
  localparam logic [7:0] ADDR_STAT_EN     = 8'h36;
  localparam logic [7:0] ADDR_SIG_EN      = 8'h3a;
  localparam logic [7:0] ADDR_DMA_STATE   = 8'h54;
  localparam logic [7:0] ADDR_AUTO_STAT   = 8'h3c;
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h40;
  localparam logic [7:0] ADDR_IRQ_CLR     = 8'h44;
  localparam logic [7:0] ADDR_IRQ_EN      = 8'h48;

  // ****************************************
  // flag positions
  // ****************************************
  localparam int BIT_CMD_TMO   = 0;
  localparam int BIT_CMD_CRC   = 1;
  localparam int BIT_CMD_END   = 2;
  localparam int BIT_CMD_IDX   = 3;
  localparam int BIT_DAT_TMO   = 4;
  localparam int BIT_DAT_CRC   = 5;
  localparam int BIT_DAT_END   = 6;
  localparam int BIT_CUR_LIM   = 7;
  localparam int BIT_AUTO_STOP = 8;
  localparam int BIT_DMA       = 9;
  localparam int BIT_TUNE      = 10;
  localparam int BIT_RSVD      = 11;
  localparam int BIT_VEND_LO   = 12;

  localparam logic [15:0] FLAGS_RESET  = 16'h0000;
  localparam logic [15:0] FLAGS_MASK   = 16'hf7ff;
  localparam logic [15:0] EN_RESET     = 16'h0000;
  localparam logic [2:0]  WCRC_GOOD    = 3'h2;
  localparam logic [1:0]  DMA_ST_FETCH = 2'h1;

  // ****************************************
  // timing
  // ****************************************
  localparam int RESP_WAIT_CYC = 64;
  localparam int CYC_W         = 7;

  // ****************************************
  // irq-cause bits
  // ****************************************
  localparam int IRQ_FLAG_SET = 0;
  localparam int IRQ_TUNE_WIN = 1;
  localparam int IRQ_W        = 2;

endpackage

// file: src/heis_resp_timer.sv
// heis_resp_timer: counts card-bus clock ticks after a command end
// assumes bus_tick is a one-cycle enable in the core_clk domain
`timescale 1ns/100ps
module heis_resp_timer
  import heis_pkg::*;
#(
  parameter int WAIT_CYC = heis_pkg::RESP_WAIT_CYC
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic bus_tick,
  input  wire logic cmd_sent,
  input  wire logic resp_seen,
  // result
  output logic      expired_r
);

  // the counter is CYC_W bits wide, so longer waits cannot be served
  if (WAIT_CYC < 1 || WAIT_CYC > 127)
  begin
    $error("WAIT_CYC out of range");
  end

  logic [CYC_W-1:0] cnt_r;
  logic             run_r;

  // counts bus ticks while waiting for a response
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_r     <= '0;
      run_r     <= 1'b0;
      expired_r <= 1'b0;
    end
    else
    begin
      expired_r <= 1'b0;
      if (cmd_sent)
      begin
        run_r <= 1'b1;
        cnt_r <= '0;
      end
      else if (resp_seen)
        run_r <= 1'b0;
      else if (run_r && bus_tick)
      begin
        if (cnt_r == CYC_W'(WAIT_CYC - 1))
        begin
          run_r     <= 1'b0;
          expired_r <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule

// file: src/heis_irq.sv
// heis_irq: sticky cause bits, write-one clear, enable, level output
// assumes clr strobes come from the register port of the same clock
`timescale 1ns/100ps
module heis_irq
  import heis_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // events and software
  input  wire logic [IRQ_W-1:0]  evt,
  input  wire logic              clr_we,
  input  wire logic              en_we,
  input  wire logic [IRQ_W-1:0]  wdata,
  // state
  output logic      [IRQ_W-1:0]  stat_r,
  output logic      [IRQ_W-1:0]  en_r,
  output logic                   irq_r
);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      stat_r <= '0;
    else
      stat_r <= (stat_r & ~(clr_we ? wdata : '0)) | evt;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      en_r <= '0;
    else if (en_we)
      en_r <= wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(((stat_r & ~(clr_we ? wdata : '0)) | evt) & en_r);
  end

endmodule

// file: src/heis_top.sv
// heis_top: error event flags of a card host controller
// assumes error detectors share core_clk; pin-level inputs are synchronised here
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module heis_top
  import heis_pkg::*;
#(
  parameter bit HAS_CUR_LIMIT = 1'b1,
  parameter int WAIT_CYC      = heis_pkg::RESP_WAIT_CYC
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // command path events
  input  wire logic        bus_tick,
  input  wire logic        cmd_sent,
  input  wire logic        resp_seen,
  input  wire logic        cmd_done,
  input  wire logic        cmd_crc_bad,
  input  wire logic        cmd_end_zero,
  input  wire logic        cmd_idx_bad,
  // data path events
  input  wire logic        dat_timeout,
  input  wire logic        dat_rd_crc_bad,
  input  wire logic        dat_wtok_valid,
  input  wire logic [2:0]  dat_wtok,
  input  wire logic        dat_end_sample,
  input  wire logic        dat_end_bit,
  input  wire logic        xfer_active,
  // power, auto stop, dma, tuning, vendor
  input  wire logic        pwr_fault_pin,
  input  wire logic [4:0]  auto_stop_command_fault,
  input  wire logic        dma_err,
  input  wire logic        dma_desc_valid_n,
  input  wire logic [1:0]  dma_state,
  input  wire logic        tune_fault,
  input  wire logic        tune_running,
  input  wire logic [3:0]  vend_err,
  // outputs
  output logic             err_irq_r,
  output logic             cmd_interrupted_r,
  output logic             evt_irq_r
);

  // ****************************************
  // pin synchroniser
  // ****************************************
  logic pwr_meta_r;
  logic pwr_sync_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pwr_meta_r <= 1'b0;
      pwr_sync_r <= 1'b0;
    end
    else
    begin
      pwr_meta_r <= pwr_fault_pin;
      pwr_sync_r <= pwr_meta_r;
    end
  end

  // ****************************************
  // command timeout
  // ****************************************
  logic resp_expired;

  heis_resp_timer #(
    .WAIT_CYC  (WAIT_CYC)
  ) u_timer (
    .core_clk  (core_clk),
    .rst       (rst),
    .bus_tick  (bus_tick),
    .cmd_sent  (cmd_sent),
    .resp_seen (resp_seen),
    .expired_r (resp_expired)
  );

  // ****************************************
  // register state
  // ****************************************
  logic [15:0] flags_r;
  logic [15:0] flags_nxt;
  logic [15:0] stat_en_r;
  logic [15:0] sig_en_r;
  logic [15:0] raw_evt;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [4:0]  auto_prev_r;
  logic [1:0]  dma_state_r;
  logic        tune_hold_r;
  logic        wr_flags;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic        irq_line;
  logic        dma_hit;

  assign wr_flags = reg_wr && (reg_addr == ADDR_FLAGS);
  assign dma_hit  = dma_err || (dma_desc_valid_n && dma_state == DMA_ST_FETCH);

  // raw events by position
  always_comb
  begin
    raw_evt                = '0;
    raw_evt[BIT_CMD_TMO]   = resp_expired;
    raw_evt[BIT_CMD_CRC]   = cmd_crc_bad;
    raw_evt[BIT_CMD_END]   = cmd_end_zero;
    raw_evt[BIT_CMD_IDX]   = cmd_idx_bad;
    raw_evt[BIT_DAT_TMO]   = dat_timeout;
    raw_evt[BIT_DAT_CRC]   = dat_rd_crc_bad || (dat_wtok_valid && dat_wtok != WCRC_GOOD);
    raw_evt[BIT_DAT_END]   = dat_end_sample && !dat_end_bit;
    raw_evt[BIT_CUR_LIM]   = HAS_CUR_LIMIT && pwr_sync_r;
    raw_evt[BIT_AUTO_STOP] = |(auto_stop_command_fault & ~auto_prev_r);
    raw_evt[BIT_DMA]       = dma_hit;
    raw_evt[BIT_TUNE]      = tune_fault && !tune_running;
    raw_evt[15:BIT_VEND_LO] = vend_err;
  end

  // tuning error suppresses other data-transfer errors in that transfer
  always_ff @(posedge core_clk)
  begin
    if (rst)
      tune_hold_r <= 1'b0;
    else if (!xfer_active)
      tune_hold_r <= 1'b0;
    else if (raw_evt[BIT_TUNE])
      tune_hold_r <= 1'b1;
  end

  always_comb
  begin
    set_vec = raw_evt & stat_en_r & FLAGS_MASK;
    if ((raw_evt[BIT_TUNE] && xfer_active) || tune_hold_r)
      set_vec = set_vec & ~16'h0070 & ~16'h0200 & ~16'h0100;
    clr_vec   = wr_flags ? reg_wdata : '0;
    flags_nxt = ((flags_r & ~clr_vec) | set_vec) & FLAGS_MASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      flags_r <= FLAGS_RESET;
    else
      flags_r <= flags_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      auto_prev_r <= '0;
    else
      auto_prev_r <= auto_stop_command_fault;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      dma_state_r <= '0;
    else if (dma_hit)
      dma_state_r <= dma_state;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      stat_en_r <= EN_RESET;
      sig_en_r  <= EN_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_STAT_EN)
        stat_en_r <= reg_wdata & FLAGS_MASK;
      if (reg_addr == ADDR_SIG_EN)
        sig_en_r <= reg_wdata & FLAGS_MASK;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      err_irq_r         <= 1'b0;
      cmd_interrupted_r <= 1'b0;
    end
    else
    begin
      err_irq_r         <= |(flags_nxt & sig_en_r);
      cmd_interrupted_r <= flags_nxt[BIT_CMD_TMO] && cmd_done;
    end
  end

  // ****************************************
  // block interrupt cause register
  // ****************************************
  assign irq_evt = {raw_evt[BIT_TUNE], |set_vec};

  heis_irq u_irq (
    .core_clk (core_clk),
    .rst      (rst),
    .evt      (irq_evt),
    .clr_we   (reg_wr && reg_addr == ADDR_IRQ_CLR),
    .en_we    (reg_wr && reg_addr == ADDR_IRQ_EN),
    .wdata    (reg_wdata[IRQ_W-1:0]),
    .stat_r   (irq_stat),
    .en_r     (irq_en),
    .irq_r    (irq_line)
  );

  always_ff @(posedge core_clk)
  begin
    if (rst)
      evt_irq_r <= 1'b0;
    else
      evt_irq_r <= irq_line;
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_FLAGS:     reg_rdata <= flags_r;
        ADDR_STAT_EN:   reg_rdata <= stat_en_r;
        ADDR_SIG_EN:    reg_rdata <= sig_en_r;
        ADDR_DMA_STATE: reg_rdata <= {14'h0000, dma_state_r};
        ADDR_AUTO_STAT: reg_rdata <= {11'h000, auto_stop_command_fault};
        ADDR_IRQ_STAT:  reg_rdata <= {14'h0000, irq_stat};
        ADDR_IRQ_EN:    reg_rdata <= {14'h0000, irq_en};
        default:        reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // ****************************************
  // checks
  // ****************************************
  AST_CLEAR_ONES: assert property (@(posedge core_clk) disable iff (rst)
    (wr_flags && reg_wdata[0] && !set_vec[0]) |=> !flags_r[0])
    else $error("write one did not clear flag");
  AST_KEEP_ZEROS: assert property (@(posedge core_clk) disable iff (rst)
    (flags_r[1] && !(wr_flags && reg_wdata[1])) |=> flags_r[1])
    else $error("flag lost without clear");
  AST_SET_WINS: assert property (@(posedge core_clk) disable iff (rst)
    (wr_flags && set_vec[4]) |=> flags_r[4])
    else $error("set lost to clear");
  AST_STAT_EN: assert property (@(posedge core_clk) disable iff (rst)
    (!stat_en_r[3] && !flags_r[3] && !wr_flags) |=> !flags_r[3])
    else $error("flag recorded while disabled");
  AST_RSVD: assert property (@(posedge core_clk) disable iff (rst)
    !flags_r[BIT_RSVD])
    else $error("reserved bit set");
  AST_IRQ: assert property (@(posedge core_clk) disable iff (rst)
    err_irq_r == |(flags_r & $past(sig_en_r)))
    else $error("interrupt line wrong");
  AST_TUNE: assert property (@(posedge core_clk) disable iff (rst)
    (tune_running && !flags_r[BIT_TUNE]) |=> !flags_r[BIT_TUNE])
    else $error("tuning flag during tuning");
  AST_AUTO: assert property (@(posedge core_clk) disable iff (rst)
    ((|(auto_stop_command_fault & ~$past(auto_stop_command_fault))) && stat_en_r[BIT_AUTO_STOP]
      && !raw_evt[BIT_TUNE] && !tune_hold_r) |=> flags_r[BIT_AUTO_STOP])
    else $error("auto stop fault missed");
  AST_CURLIM: assert property (@(posedge core_clk) disable iff (rst)
    (pwr_sync_r && stat_en_r[BIT_CUR_LIM]) |=> (flags_r[BIT_CUR_LIM] == HAS_CUR_LIMIT))
    else $error("current limit flag wrong");
  AST_TMO_SET: assert property (@(posedge core_clk) disable iff (rst)
    (resp_expired && stat_en_r[BIT_CMD_TMO]) |=> flags_r[BIT_CMD_TMO])
    else $error("command timeout not recorded");
  AST_INTERRUPTED: assert property (@(posedge core_clk) disable iff (rst)
    (flags_r[BIT_CMD_TMO] && !wr_flags && cmd_done) |=> cmd_interrupted_r)
    else $error("interrupted command not flagged");
  AST_DMA_STATE: assert property (@(posedge core_clk) disable iff (rst)
    (dma_desc_valid_n && dma_state == DMA_ST_FETCH) |=> (dma_state_r == DMA_ST_FETCH))
    else $error("fetch state not captured");
  AST_DAT_CRC: assert property (@(posedge core_clk) disable iff (rst)
    (dat_wtok_valid && dat_wtok != WCRC_GOOD && stat_en_r[BIT_DAT_CRC]
      && !raw_evt[BIT_TUNE] && !tune_hold_r) |=> flags_r[BIT_DAT_CRC])
    else $error("bad write token not recorded");
  AST_DAT_END: assert property (@(posedge core_clk) disable iff (rst)
    (dat_end_sample && dat_end_bit && !flags_r[BIT_DAT_END]) |=> !flags_r[BIT_DAT_END])
    else $error("end bit error on a good end bit");
  AST_IRQ_OFF: assert property (@(posedge core_clk) disable iff (rst)
    !(|sig_en_r) |=> !err_irq_r)
    else $error("interrupt without signal enable");
  AST_VEND: assert property (@(posedge core_clk) disable iff (rst)
    (vend_err[0] && stat_en_r[BIT_VEND_LO]) |=> flags_r[BIT_VEND_LO])
    else $error("vendor flag not recorded");
  AST_RESET_CLEAR: assert property (@(posedge core_clk)
    (!rst && $past(rst)) |-> (flags_r == FLAGS_RESET))
    else $error("flags not cleared by reset");

  // a tuning fault seen while a transfer runs
  sequence seq_tune_in_xfer;
    raw_evt[BIT_TUNE] && xfer_active;
  endsequence

  // the same transfer goes on with its data flags clear
  sequence seq_data_flags_quiet;
    xfer_active && !(|flags_r[BIT_DAT_END:BIT_DAT_TMO]);
  endsequence

  AST_TUNE_FIRST: assert property (@(posedge core_clk) disable iff (rst)
    (seq_tune_in_xfer ##1 seq_data_flags_quiet) |=> !(|flags_r[BIT_DAT_END:BIT_DAT_TMO]))
    else $error("data error recorded after tuning error");

endmodule

// file: tb/heis_card_model.sv
// heis_card_model: card-side stand-in for bus clock ticks and command responses
// assumes core_clk domain; a resp_delay of zero means the card never answers
`timescale 1ns/100ps
module heis_card_model
(
  // clock
  input  wire logic       core_clk,
  // command path
  input  wire logic       cmd_sent,
  input  wire logic [7:0] resp_delay,
  output logic            bus_tick,
  output logic            resp_seen
);
  logic [1:0] div_r = 2'h0;
  logic [7:0] cnt_r = 8'h00;
  logic       busy_r = 1'b0;

  initial
  begin
    bus_tick = 1'b0;
    resp_seen = 1'b0;
  end

  // one bus clock per four core clocks
  always @(posedge core_clk)
  begin
    div_r <= div_r + 2'h1;
    bus_tick <= (div_r == 2'h3);
  end

  // answer after resp_delay bus clocks, or stay silent
  always @(posedge core_clk)
  begin
    resp_seen <= 1'b0;
    if (cmd_sent)
    begin
      busy_r <= 1'b1;
      cnt_r <= 8'h00;
    end
    else if (busy_r && bus_tick)
    begin
      cnt_r <= cnt_r + 8'h01;
      if (resp_delay != 8'h00 && cnt_r + 8'h01 == resp_delay)
      begin
        resp_seen <= 1'b1;
        busy_r <= 1'b0;
      end
    end
  end
endmodule

// file: tb/heis_top_tb.sv
// heis_top_tb: self-checking bench for the error event flag block
// assumes heis_pkg register indices; response wait shortened to four bus clocks
`timescale 1ns/100ps
module heis_top_tb;
  import heis_pkg::*;
  localparam int WAIT_T = 4;

  // ****************************************
  // signals
  // ****************************************
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] ev_v = 16'h0000;
  logic        cmd_sent = 1'b0;
  logic        cmd_done = 1'b0;
  logic [2:0]  dat_wtok = 3'h0;
  logic        dat_end_bit = 1'b0;
  logic        xfer_active = 1'b0;
  logic        pwr_fault_pin = 1'b0;
  logic [4:0]  auto_fault = 5'h00;
  logic [1:0]  dma_state = 2'h0;
  logic        tune_running = 1'b0;
  logic [7:0]  resp_delay = 8'h00;
  logic        bus_tick;
  logic        resp_seen;
  logic        err_irq_r;
  logic        cmd_interrupted_r;
  logic        evt_irq_r;
  logic        rd_d = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] m;
  int          bad_count = 0;
  int          num_checks = 0;
  int          causes[12] = '{1, 2, 3, 4, 5, 6, 9, 10, 12, 13, 14, 15};

  always #20 core_clk = ~core_clk;

  heis_card_model card (.core_clk(core_clk), .cmd_sent(cmd_sent), .resp_delay(resp_delay),
    .bus_tick(bus_tick), .resp_seen(resp_seen));

  // spare bits 0 and 11 carry the invalid-descriptor and write-token strobes
  heis_top #(.HAS_CUR_LIMIT(1'b1), .WAIT_CYC(WAIT_T)) dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_tick(bus_tick), .cmd_sent(cmd_sent),
    .resp_seen(resp_seen), .cmd_done(cmd_done), .cmd_crc_bad(ev_v[1]),
    .cmd_end_zero(ev_v[2]), .cmd_idx_bad(ev_v[3]), .dat_timeout(ev_v[4]),
    .dat_rd_crc_bad(ev_v[5]), .dat_wtok_valid(ev_v[11]), .dat_wtok(dat_wtok),
    .dat_end_sample(ev_v[6]), .dat_end_bit(dat_end_bit), .xfer_active(xfer_active),
    .pwr_fault_pin(pwr_fault_pin), .auto_stop_command_fault(auto_fault),
    .dma_err(ev_v[9]), .dma_desc_valid_n(ev_v[0]), .dma_state(dma_state),
    .tune_fault(ev_v[10]), .tune_running(tune_running), .vend_err(ev_v[15:12]),
    .err_irq_r(err_irq_r), .cmd_interrupted_r(cmd_interrupted_r), .evt_irq_r(evt_irq_r));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                     input logic [15:0] d, input logic [15:0] e);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    ev_v <= e;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cyc(1'b1, 1'b0, a, d, 16'h0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    cyc(1'b0, 1'b1, a, 16'h0000, 16'h0000);
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 8'h00, 16'h0000, 16'h0000);
  endtask

  task automatic pulse(input logic [15:0] e);
    cyc(1'b0, 1'b0, 8'h00, 16'h0000, e);
  endtask

  task automatic send_cmd;
    cmd_sent <= 1'b1;
    idle(1);
    cmd_sent <= 1'b0;
    idle(40);
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // read data stand in the cycle after the strobe
  always @(posedge core_clk)
  begin
    if (rd_d)
      check_word(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    void'($urandom(84996));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    idle(1);
    rd(ADDR_FLAGS, 16'h0000);
    pulse(16'hf67e);
    rd(ADDR_FLAGS, 16'h0000);
    wr(ADDR_STAT_EN, 16'hffff);
    wr(ADDR_SIG_EN, 16'h0000);
    foreach (causes[i])
    begin
      pulse(16'h0001 << causes[i]);
      rd(ADDR_FLAGS, 16'h0001 << causes[i]);
      wr(ADDR_FLAGS, 16'hffff);
    end
    for (int k = 0; k < 8; k++)
    begin
      dat_wtok <= k[2:0];
      pulse(16'h0800);
      rd(ADDR_FLAGS, (k == 2) ? 16'h0000 : 16'h0020);
      wr(ADDR_FLAGS, 16'hffff);
    end
    dat_end_bit <= 1'b1;
    pulse(16'h0040);
    rd(ADDR_FLAGS, 16'h0000);
    dat_end_bit <= 1'b0;
    dma_state <= DMA_ST_FETCH;
    pulse(16'h0001);
    rd(ADDR_FLAGS, 16'h0200);
    rd(ADDR_DMA_STATE, {14'h0000, DMA_ST_FETCH});
    wr(ADDR_FLAGS, 16'hffff);
    // random partial clear, reserved bit untouched
    pulse(16'hf67e);
    m = 16'($urandom);
    wr(ADDR_FLAGS, m);
    rd(ADDR_FLAGS, 16'hf67e & ~m);
    wr(ADDR_FLAGS, 16'hffff);
    pulse(16'h0002);
    cyc(1'b1, 1'b0, ADDR_FLAGS, 16'h0012, 16'h0012);
    idle(5);
    rd(ADDR_FLAGS, 16'h0012);
    check_word({15'h0000, err_irq_r}, 16'h0000);
    wr(ADDR_SIG_EN, 16'h0002);
    idle(2);
    check_word({15'h0000, err_irq_r}, 16'h0001);
    wr(ADDR_SIG_EN, 16'h0004);
    idle(2);
    check_word({15'h0000, err_irq_r}, 16'h0000);
    wr(ADDR_IRQ_EN, 16'h0001);
    rd(ADDR_IRQ_STAT, 16'h0003);
    idle(2);
    check_word({15'h0000, evt_irq_r}, 16'h0001);
    wr(ADDR_IRQ_CLR, 16'h0003);
    wr(ADDR_IRQ_EN, 16'h0000);
    rd(ADDR_IRQ_STAT, 16'h0000);
    pulse(16'h0010);
    idle(2);
    check_word({15'h0000, evt_irq_r}, 16'h0000);
    rd(ADDR_IRQ_STAT, 16'h0001);
    wr(ADDR_FLAGS, 16'hffff);
    resp_delay <= 8'h03;
    send_cmd();
    rd(ADDR_FLAGS, 16'h0000);
    resp_delay <= 8'h00;
    send_cmd();
    rd(ADDR_FLAGS, 16'h0001);
    cmd_done <= 1'b1;
    idle(2);
    check_word({15'h0000, cmd_interrupted_r}, 16'h0001);
    cmd_done <= 1'b0;
    wr(ADDR_FLAGS, 16'hffff);
    pwr_fault_pin <= 1'b1;
    idle(6);
    rd(ADDR_FLAGS, 16'h0080);
    pwr_fault_pin <= 1'b0;
    idle(6);
    wr(ADDR_FLAGS, 16'hffff);
    auto_fault <= 5'h10;
    idle(2);
    rd(ADDR_FLAGS, 16'h0100);
    rd(ADDR_AUTO_STAT, 16'h0010);
    wr(ADDR_FLAGS, 16'hffff);
    idle(2);
    rd(ADDR_FLAGS, 16'h0000);
    tune_running <= 1'b1;
    pulse(16'h0400);
    rd(ADDR_FLAGS, 16'h0000);
    tune_running <= 1'b0;
    xfer_active <= 1'b1;
    pulse(16'h0400);
    pulse(16'h0070);
    rd(ADDR_FLAGS, 16'h0400);
    // software aborts the transfer, clears the flags and retries it
    xfer_active <= 1'b0;
    idle(1);
    wr(ADDR_FLAGS, 16'hffff);
    xfer_active <= 1'b1;
    pulse(16'h0070);
    rd(ADDR_FLAGS, 16'h0070);
    xfer_active <= 1'b0;
    idle(3);
    end_of_test();
  end
endmodule
